// File: inc/pdc_pkg.sv
// shared constants for the pll divider configuration ends
package pdc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_BANK1     = 8'h0C;
  localparam logic [7:0] ADDR_LOAD_CAP  = 8'h13;
  localparam logic [7:0] ADDR_PUMP_FBHI = 8'h40;
  localparam logic [7:0] ADDR_FB_LOW    = 8'h41;
  localparam logic [7:0] ADDR_ODD_REF   = 8'h42;
  localparam logic [7:0] ADDR_BANK2     = 8'h47;
  // field layout
  localparam int SRC_BIT      = 7;
  localparam int DIVN_MSB     = 6;
  localparam int ODD_BIT      = 7;
  localparam int REFDIV_MSB   = 6;
  localparam int PUMP_MSB     = 4;
  localparam int PUMP_LSB     = 2;
  localparam int FBHI_MSB     = 1;
  localparam int FIXED_LSB    = 5;
  localparam logic [2:0] FIXED_PATTERN = 3'h6;
  // reset values
  localparam logic [6:0] DIVN_RESET   = 7'h08;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  // arithmetic
  localparam logic [11:0] FB_BASE_OFFSET = 12'h004;
  localparam logic [11:0] REF_DIV_OFFSET = 12'h002;
  localparam logic [11:0] FIXED_DIV2     = 12'h002;
  localparam logic [11:0] FIXED_DIV3     = 12'h003;
  localparam logic [11:0] FIXED_DIV4     = 12'h004;
  // host-side limits
  localparam logic [6:0]  DIVN_MIN     = 7'h04;
  localparam logic [2:0]  PUMP_MAX_OK  = 3'h4;
  localparam logic [11:0] P_STABLE_MIN = 12'h010;
  localparam logic [11:0] P_STABLE_MAX = 12'h3FF;
  localparam logic [11:0] PUMP_EDGE_1  = 12'h02D;
  localparam logic [11:0] PUMP_EDGE_2  = 12'h1E0;
  localparam logic [11:0] PUMP_EDGE_3  = 12'h280;
  localparam logic [11:0] PUMP_EDGE_4  = 12'h320;
  localparam logic [31:0] VCO_MIN_KHZ  = 32'h0001_86A0;
  localparam logic [31:0] VCO_MAX_KHZ  = 32'h0006_1A80;
  // host software port map
  localparam logic [3:0] HOST_TARGET  = 4'h0;
  localparam logic [3:0] HOST_WDATA   = 4'h1;
  localparam logic [3:0] HOST_READ    = 4'h2;
  localparam logic [3:0] HOST_STATUS  = 4'h3;
  localparam logic [3:0] HOST_RDDATA  = 4'h4;
  localparam int ST_REFUSED = 0;
  localparam int ST_PUMP    = 1;
  localparam int ST_PRANGE  = 2;
  localparam int ST_VCO     = 3;
endpackage : pdc_pkg

// File: inc/pdc_if.sv
// register access link between host controller and divider device
`timescale 1ns/100ps
interface pdc_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport dev  (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : pdc_if

// File: hw/pdc_device.sv
// pll divider configuration device: registers, feedback, reference and bank dividers
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
// Overview of operation
// - factor is twice base plus four, plus odd
// - base count: 0x40 bits 1..0, 0x41 low
// - 0x40 bits 7..5 fixed at 110
// - odd bit lives in 0x42 bit 7
// - 0x42 bits 6..0 hold reference divider
// - feedback factor spans 8 to 2055
// - host flags vco outside 100 to 400 MHz in status
// - bit 7 picks vco or reference per bank
// - each bank gives /2, /3, /4, /divisor
// - divisor is bits 6..0, host keeps 4..127
// - pump code sits in 0x40 bits 4..2
// - host flags pump code not matching factor range
// - host never writes pump codes 101..111
// - host flags factor outside 16 to 1023 in status
// - reference divided by field plus two
// - 0x13 holds eight bit load cap code
module pdc_device (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  pdc_if.dev                     link,
  input  wire logic              ref_tick_i,
  input  wire logic              vco_tick_i,
  output logic                   ref_div_tick_o,
  output logic                   fb_div_tick_o,
  output logic [1:0][3:0]        bank_tick_o,
  output logic [2:0]             pump_code_o,
  output logic [7:0]             load_cap_code_o,
  output logic [11:0]            feedback_factor_o
);
  localparam int NDIV = 10;

  typedef enum {
    PDC_SEL_NONE, PDC_SEL_BANK1, PDC_SEL_CAP, PDC_SEL_PUMP,
    PDC_SEL_FBLO, PDC_SEL_ODDREF, PDC_SEL_BANK2
  } pdc_sel_e;

  function automatic pdc_sel_e pdc_decode(input logic [7:0] a);
    case (a)
      pdc_pkg::ADDR_BANK1:     pdc_decode = PDC_SEL_BANK1;
      pdc_pkg::ADDR_LOAD_CAP:  pdc_decode = PDC_SEL_CAP;
      pdc_pkg::ADDR_PUMP_FBHI: pdc_decode = PDC_SEL_PUMP;
      pdc_pkg::ADDR_FB_LOW:    pdc_decode = PDC_SEL_FBLO;
      pdc_pkg::ADDR_ODD_REF:   pdc_decode = PDC_SEL_ODDREF;
      pdc_pkg::ADDR_BANK2:     pdc_decode = PDC_SEL_BANK2;
      default:                 pdc_decode = PDC_SEL_NONE;
    endcase
  endfunction : pdc_decode

  // register file
  logic [1:0]       bank_src_reg;
  logic [1:0]       bank_src_next;
  logic [1:0][6:0]  bank_divisor_reg;
  logic [1:0][6:0]  bank_divisor_next;
  logic [7:0]       load_cap_code_reg;
  logic [7:0]       load_cap_code_next;
  logic [2:0]       pump_code_reg;
  logic [2:0]       pump_code_next;
  logic [9:0]       feedback_base_count_reg;
  logic [9:0]       feedback_base_count_next;
  logic             feedback_odd_bit_reg;
  logic             feedback_odd_bit_next;
  logic [6:0]       ref_div_field_reg;
  logic [6:0]       ref_div_field_next;
  logic [7:0]       rdata_reg;
  logic [7:0]       rdata_next;
  logic [11:0]      factor_reg;
  logic [11:0]      factor_next;
  pdc_sel_e         wsel;
  pdc_sel_e         rsel;

  always_comb begin
    wsel                     = pdc_decode(link.addr);
    rsel                     = pdc_decode(link.addr);
    bank_src_next            = bank_src_reg;
    bank_divisor_next        = bank_divisor_reg;
    load_cap_code_next       = load_cap_code_reg;
    pump_code_next           = pump_code_reg;
    feedback_base_count_next = feedback_base_count_reg;
    feedback_odd_bit_next    = feedback_odd_bit_reg;
    ref_div_field_next       = ref_div_field_reg;
    rdata_next               = pdc_pkg::BYTE_RESET;
    if (link.wr) begin
      case (wsel)
        PDC_SEL_BANK1: begin
          bank_src_next[0]     = link.wdata[pdc_pkg::SRC_BIT];
          bank_divisor_next[0] = link.wdata[pdc_pkg::DIVN_MSB:0];
        end
        PDC_SEL_BANK2: begin
          bank_src_next[1]     = link.wdata[pdc_pkg::SRC_BIT];
          bank_divisor_next[1] = link.wdata[pdc_pkg::DIVN_MSB:0];
        end
        PDC_SEL_CAP: load_cap_code_next = link.wdata;
        PDC_SEL_PUMP: begin
          // upper three bits are not stored, so writes cannot change them
          pump_code_next = link.wdata[pdc_pkg::PUMP_MSB:pdc_pkg::PUMP_LSB];
          feedback_base_count_next[9:8] = link.wdata[pdc_pkg::FBHI_MSB:0];
        end
        PDC_SEL_FBLO: feedback_base_count_next[7:0] = link.wdata;
        PDC_SEL_ODDREF: begin
          feedback_odd_bit_next = link.wdata[pdc_pkg::ODD_BIT];
          ref_div_field_next    = link.wdata[pdc_pkg::REFDIV_MSB:0];
        end
        default: ;
      endcase
    end
    if (link.rd) begin
      case (rsel)
        PDC_SEL_BANK1:  rdata_next = {bank_src_reg[0], bank_divisor_reg[0]};
        PDC_SEL_BANK2:  rdata_next = {bank_src_reg[1], bank_divisor_reg[1]};
        PDC_SEL_CAP:    rdata_next = load_cap_code_reg;
        PDC_SEL_PUMP:   rdata_next = {pdc_pkg::FIXED_PATTERN, pump_code_reg,
                                      feedback_base_count_reg[9:8]};
        PDC_SEL_FBLO:   rdata_next = feedback_base_count_reg[7:0];
        PDC_SEL_ODDREF: rdata_next = {feedback_odd_bit_reg, ref_div_field_reg};
        default:        rdata_next = pdc_pkg::BYTE_RESET;
      endcase
    end
    // factor spans 8..2055 by construction of the 12-bit sum
    factor_next = 12'({feedback_base_count_reg, 1'b0}
                      + {pdc_pkg::FB_BASE_OFFSET[10:0], 1'b0})
                  + {11'h000, feedback_odd_bit_reg};
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bank_src_reg            <= 2'h0;
      bank_divisor_reg        <= {pdc_pkg::DIVN_RESET, pdc_pkg::DIVN_RESET};
      load_cap_code_reg       <= pdc_pkg::BYTE_RESET;
      pump_code_reg           <= 3'h0;
      feedback_base_count_reg <= 10'h000;
      feedback_odd_bit_reg    <= 1'b0;
      ref_div_field_reg       <= 7'h00;
      rdata_reg               <= pdc_pkg::BYTE_RESET;
      factor_reg              <= 12'h000;
    end else begin
      bank_src_reg            <= bank_src_next;
      bank_divisor_reg        <= bank_divisor_next;
      load_cap_code_reg       <= load_cap_code_next;
      pump_code_reg           <= pump_code_next;
      feedback_base_count_reg <= feedback_base_count_next;
      feedback_odd_bit_reg    <= feedback_odd_bit_next;
      ref_div_field_reg       <= ref_div_field_next;
      rdata_reg               <= rdata_next;
      factor_reg              <= factor_next;
    end
  end

  // dividers: 0 reference, 1 feedback, 2..9 bank b /2,/3,/4,/divisor
  logic [NDIV-1:0]        div_in;
  logic [NDIV-1:0][11:0]  div_load;
  wire logic [NDIV-1:0]   tick_all;

  always_comb begin
    div_in      = '0;
    div_load    = '0;
    div_in[0]   = ref_tick_i;
    div_load[0] = {5'h00, ref_div_field_reg} + pdc_pkg::REF_DIV_OFFSET;
    div_in[1]   = vco_tick_i;
    div_load[1] = factor_next;
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 4; k++) begin
        div_in[2 + 4*b + k] = bank_src_reg[b] ? ref_tick_i : vco_tick_i;
      end
      div_load[2 + 4*b]     = pdc_pkg::FIXED_DIV2;
      div_load[2 + 4*b + 1] = pdc_pkg::FIXED_DIV3;
      div_load[2 + 4*b + 2] = pdc_pkg::FIXED_DIV4;
      div_load[2 + 4*b + 3] = {5'h00, bank_divisor_next[b]};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NDIV; gi++) begin : g_div
      // per-divider state kept local so each variable has a single process
      logic [11:0] cnt_reg;
      logic [11:0] cnt_next;
      logic [11:0] term_reg;
      logic [11:0] term_next;
      logic        tick_reg;
      logic        tick_next;
      // term is only reloaded at wrap, so a mid-period write never cuts a pulse short
      always_comb begin
        cnt_next  = cnt_reg;
        term_next = term_reg;
        tick_next = 1'b0;
        if (div_in[gi]) begin
          if (cnt_reg + 12'h001 >= term_reg) begin
            cnt_next  = 12'h000;
            term_next = div_load[gi];
            tick_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 12'h001;
          end
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          cnt_reg  <= 12'h000;
          term_reg <= 12'h000;
          tick_reg <= 1'b0;
        end else begin
          cnt_reg  <= cnt_next;
          term_reg <= term_next;
          tick_reg <= tick_next;
        end
      end

      assign tick_all[gi] = tick_reg;
    end
  endgenerate

  assign link.rdata        = rdata_reg;
  assign ref_div_tick_o    = tick_all[0];
  assign fb_div_tick_o     = tick_all[1];
  assign bank_tick_o[0]    = tick_all[5:2];
  assign bank_tick_o[1]    = tick_all[9:6];
  assign pump_code_o       = pump_code_reg;
  assign load_cap_code_o   = load_cap_code_reg;
  assign feedback_factor_o = factor_reg;
endmodule : pdc_device

// File: hw/pdc_host.sv
// host controller: software port, write screening and frequency plan checks
`timescale 1ns/100ps
module pdc_host #(
  parameter logic [17:0] REF_KHZ = 18'h04E20
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  pdc_if.host              link,
  input  wire logic [3:0]  sw_addr_i,
  input  wire logic [7:0]  sw_wdata_i,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_rd_i,
  output logic [7:0]       sw_rdata_o
);
  function automatic logic [2:0] pdc_pump_for(input logic [11:0] p);
    if (p < pdc_pkg::PUMP_EDGE_1)      pdc_pump_for = 3'h0;
    else if (p < pdc_pkg::PUMP_EDGE_2) pdc_pump_for = 3'h1;
    else if (p < pdc_pkg::PUMP_EDGE_3) pdc_pump_for = 3'h2;
    else if (p < pdc_pkg::PUMP_EDGE_4) pdc_pump_for = 3'h3;
    else                               pdc_pump_for = 3'h4;
  endfunction : pdc_pump_for

  logic [7:0]  target_reg, target_next;
  logic [7:0]  addr_reg, addr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        wr_reg, wr_next;
  logic        rd_reg, rd_next;
  logic        rd_wait_reg, rd_wait_next;
  logic [7:0]  rddata_reg, rddata_next;
  logic [3:0]  status_reg, status_next;
  logic [7:0]  sw_rdata_reg, sw_rdata_next;
  logic [7:0]  sh_pump_reg, sh_pump_next;
  logic [7:0]  sh_low_reg, sh_low_next;
  logic [7:0]  sh_odd_reg, sh_odd_next;
  logic [11:0] p_total;
  logic [7:0]  q_total;
  logic [31:0] vco_scaled;
  logic        refuse;

  always_comb begin
    target_next  = target_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    wr_next      = 1'b0;
    rd_next      = 1'b0;
    rd_wait_next = rd_reg;
    rddata_next  = rd_wait_reg ? link.rdata : rddata_reg;
    status_next  = status_reg;
    sh_pump_next = sh_pump_reg;
    sh_low_next  = sh_low_reg;
    sh_odd_next  = sh_odd_reg;
    refuse       = 1'b0;
    if ((target_reg == pdc_pkg::ADDR_PUMP_FBHI)
        && (sw_wdata_i[pdc_pkg::PUMP_MSB:pdc_pkg::PUMP_LSB] > pdc_pkg::PUMP_MAX_OK))
      refuse = 1'b1;
    if (((target_reg == pdc_pkg::ADDR_BANK1) || (target_reg == pdc_pkg::ADDR_BANK2))
        && (sw_wdata_i[pdc_pkg::DIVN_MSB:0] < pdc_pkg::DIVN_MIN))
      refuse = 1'b1;
    if (sw_wr_i) begin
      case (sw_addr_i)
        pdc_pkg::HOST_TARGET: target_next = sw_wdata_i;
        pdc_pkg::HOST_WDATA: begin
          if (refuse) begin
            status_next[pdc_pkg::ST_REFUSED] = 1'b1;
          end else begin
            addr_next  = target_reg;
            wdata_next = sw_wdata_i;
            wr_next    = 1'b1;
            if (target_reg == pdc_pkg::ADDR_PUMP_FBHI) sh_pump_next = sw_wdata_i;
            if (target_reg == pdc_pkg::ADDR_FB_LOW)    sh_low_next  = sw_wdata_i;
            if (target_reg == pdc_pkg::ADDR_ODD_REF)   sh_odd_next  = sw_wdata_i;
          end
        end
        pdc_pkg::HOST_READ: begin
          addr_next = target_reg;
          rd_next   = 1'b1;
        end
        // refused flag clears on write of one; a same-cycle refusal cannot occur here
        pdc_pkg::HOST_STATUS:
          status_next[pdc_pkg::ST_REFUSED] = status_reg[pdc_pkg::ST_REFUSED]
                                             & ~sw_wdata_i[pdc_pkg::ST_REFUSED];
        default: ;
      endcase
    end
    // plan checks on the shadowed values, refreshed every cycle
    p_total = 12'({sh_pump_reg[pdc_pkg::FBHI_MSB:0], sh_low_reg, 1'b0}
                  + {pdc_pkg::FB_BASE_OFFSET[10:0], 1'b0})
              + {11'h000, sh_odd_reg[pdc_pkg::ODD_BIT]};
    q_total = {1'b0, sh_odd_reg[pdc_pkg::REFDIV_MSB:0]} + pdc_pkg::REF_DIV_OFFSET[7:0];
    vco_scaled = 32'({20'h00000, p_total} * {14'h0000, REF_KHZ});
    status_next[pdc_pkg::ST_PUMP] =
      (sh_pump_reg[pdc_pkg::PUMP_MSB:pdc_pkg::PUMP_LSB] != pdc_pump_for(p_total));
    status_next[pdc_pkg::ST_PRANGE] =
      (p_total < pdc_pkg::P_STABLE_MIN) || (p_total > pdc_pkg::P_STABLE_MAX);
    status_next[pdc_pkg::ST_VCO] =
      (vco_scaled < 32'(pdc_pkg::VCO_MIN_KHZ * q_total))
      || (vco_scaled > 32'(pdc_pkg::VCO_MAX_KHZ * q_total));
    sw_rdata_next = 8'h00;
    if (sw_rd_i) begin
      case (sw_addr_i)
        pdc_pkg::HOST_TARGET: sw_rdata_next = target_reg;
        pdc_pkg::HOST_STATUS: sw_rdata_next = {rd_reg | rd_wait_reg, 3'h0, status_reg};
        pdc_pkg::HOST_RDDATA: sw_rdata_next = rddata_reg;
        default:              sw_rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      target_reg   <= 8'h00;
      addr_reg     <= 8'h00;
      wdata_reg    <= 8'h00;
      wr_reg       <= 1'b0;
      rd_reg       <= 1'b0;
      rd_wait_reg  <= 1'b0;
      rddata_reg   <= 8'h00;
      status_reg   <= 4'h0;
      sw_rdata_reg <= 8'h00;
      sh_pump_reg  <= 8'h00;
      sh_low_reg   <= 8'h00;
      sh_odd_reg   <= 8'h00;
    end else begin
      target_reg   <= target_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      wr_reg       <= wr_next;
      rd_reg       <= rd_next;
      rd_wait_reg  <= rd_wait_next;
      rddata_reg   <= rddata_next;
      status_reg   <= status_next;
      sw_rdata_reg <= sw_rdata_next;
      sh_pump_reg  <= sh_pump_next;
      sh_low_reg   <= sh_low_next;
      sh_odd_reg   <= sh_odd_next;
    end
  end

  assign link.addr  = addr_reg;
  assign link.wdata = wdata_reg;
  assign link.wr    = wr_reg;
  assign link.rd    = rd_reg;
  assign sw_rdata_o = sw_rdata_reg;
endmodule : pdc_host

// File: tb/pdc_checker.sv
// concurrent checks on the register link between host and device
`timescale 1ns/100ps
module pdc_checker (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of link writes; reset values follow the device's chosen ones
  logic [7:0] bank1_reg, cap_reg, fbhi_reg, fblo_reg, oddref_reg, bank2_reg;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bank1_reg  <= 8'h08;
      cap_reg    <= 8'h00;
      fbhi_reg   <= 8'h00;
      fblo_reg   <= 8'h00;
      oddref_reg <= 8'h00;
      bank2_reg  <= 8'h08;
    end else if (wr) begin
      case (addr)
        8'h0C: bank1_reg <= wdata;
        8'h13: cap_reg <= wdata;
        8'h40: fbhi_reg <= wdata;
        8'h41: fblo_reg <= wdata;
        8'h42: oddref_reg <= wdata;
        8'h47: bank2_reg <= wdata;
        default: ;
      endcase
    end
  end
  sequence s_rd_oddref;
    rd && addr == 8'h42;
  endsequence
  property p_fixed_top;
    rd && addr == 8'h40 |=> rdata[7:5] == 3'h6;
  endproperty
  a_fixed_top: assert property (p_fixed_top)
    else $error("fixed bits of pump register read wrong");
  property p_pump;
    rd && addr == 8'h40 ##1 1'b1 |-> rdata[4:2] == $past(fbhi_reg[4:2]);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump field read back wrong");
  property p_base_hi;
    rd && addr == 8'h40 |=> rdata[1:0] == $past(fbhi_reg[1:0]);
  endproperty
  a_base_hi: assert property (p_base_hi)
    else $error("upper base count bits read back wrong");
  property p_base_lo;
    rd && addr == 8'h41 |=> rdata == $past(fblo_reg);
  endproperty
  a_base_lo: assert property (p_base_lo)
    else $error("lower base count read back wrong");
  property p_odd;
    s_rd_oddref |=> rdata[7] == $past(oddref_reg[7]);
  endproperty
  a_odd: assert property (p_odd)
    else $error("odd bit read back wrong");
  property p_refdiv;
    s_rd_oddref |=> rdata[6:0] == $past(oddref_reg[6:0]);
  endproperty
  a_refdiv: assert property (p_refdiv)
    else $error("reference divider field read back wrong");
  property p_bank1;
    rd && addr == 8'h0C |=> rdata == $past(bank1_reg);
  endproperty
  a_bank1: assert property (p_bank1)
    else $error("bank one register read back wrong");
  property p_bank2;
    rd && addr == 8'h47 |=> rdata == $past(bank2_reg);
  endproperty
  a_bank2: assert property (p_bank2)
    else $error("bank two register read back wrong");
  property p_cap;
    rd && addr == 8'h13 |=> rdata == $past(cap_reg);
  endproperty
  a_cap: assert property (p_cap)
    else $error("load cap code read back wrong");
  c_wr_pump: cover property (wr && addr == 8'h40);
  c_wr_rd: cover property (wr ##1 rd);
  c_rd_bank2: cover property (rd && addr == 8'h47);
endmodule : pdc_checker

// File: tb/tb.sv
// self-checking bench: host and device joined over the register link
`timescale 1ns/100ps
module tb;
  logic            sys_clk_i  = 1'b0;
  logic            rst_n_i    = 1'b0;
  logic [3:0]      sw_addr_i  = 4'h0;
  logic [7:0]      sw_wdata_i = 8'h00;
  logic            sw_wr_i    = 1'b0;
  logic            sw_rd_i    = 1'b0;
  logic            ref_tick_i = 1'b0;
  logic            vco_tick_i = 1'b0;
  logic [7:0]      sw_rdata_o;
  logic            ref_div_tick_o;
  logic            fb_div_tick_o;
  logic [1:0][3:0] bank_tick_o;
  logic [2:0]      pump_code_o;
  logic [7:0]      load_cap_code_o;
  logic [11:0]     feedback_factor_o;
  int              fails   = 0;
  int              n_tests = 0;
  int              m [256];
  int              cnt [10];
  int              trm [10];
  logic [9:0]      exq = 10'h000;
  logic [7:0]      seed  = 8'h3A;
  logic [7:0]      tseed = 8'h3A;
  logic            run   = 1'b0;
  logic [7:0]      v;
  int              adr [7] = '{8'h0C, 8'h13, 8'h40, 8'h41, 8'h42, 8'h47, 8'h43};
  pdc_if link ();
  pdc_host pdc_host_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i),
    .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o));
  pdc_device pdc_device_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link),
    .ref_tick_i(ref_tick_i), .vco_tick_i(vco_tick_i), .ref_div_tick_o(ref_div_tick_o),
    .fb_div_tick_o(fb_div_tick_o), .bank_tick_o(bank_tick_o), .pump_code_o(pump_code_o),
    .load_cap_code_o(load_cap_code_o), .feedback_factor_o(feedback_factor_o));
  pdc_checker pdc_checker_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
  always #5 sys_clk_i = ~sys_clk_i;
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lf
  function automatic int term(input int i);
    int k;
    k = (i - 2) % 4;
    if (i == 0) return (m[8'h42] & 127) + 2;
    if (i == 1) return 2 * (((m[8'h40] & 3) << 8) + m[8'h41] + 4) + (m[8'h42] >> 7);
    if (k < 3) return k + 2;
    return (i < 6) ? (m[8'h0C] & 127) : (m[8'h47] & 127);
  endfunction : term
  function automatic int rexp(input int a);
    if (a == 8'h40) return 8'hC0 | m[a];
    if (a == 8'h0C || a == 8'h13 || a == 8'h41 || a == 8'h42 || a == 8'h47) return m[a];
    return 0;
  endfunction : rexp
  // plan status bits 3..1 of the host: vco range, factor range, pump mismatch
  function automatic int st_exp();
    int p;
    int q;
    int pe;
    p  = term(1);
    q  = term(0);
    pe = (p < 45) ? 0 : (p < 480) ? 1 : (p < 640) ? 2 : (p < 800) ? 3 : 4;
    return (((p * 20000 < 100000 * q) || (p * 20000 > 400000 * q)) ? 4 : 0)
           + ((p < 16 || p > 1023) ? 2 : 0)
           + ((((m[8'h40] >> 2) & 7) != pe) ? 1 : 0);
  endfunction : st_exp
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic sw_w(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    sw_addr_i  <= a;
    sw_wdata_i <= d;
    sw_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    sw_wr_i <= 1'b0;
  endtask : sw_w
  task automatic sw_r(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    sw_addr_i <= a;
    sw_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask : sw_r
  task automatic dr(input logic [7:0] a);
    logic [7:0] d;
    sw_w(4'h0, a);
    sw_w(4'h2, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    sw_r(4'h4, d);
    chk("register read", 12'(rexp(a)), {4'h0, d});
  endtask : dr
  // a refused write leaves the model untouched, as the host screens it out
  task automatic dw(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    logic [7:0] s;
    ok = !((a == 8'h40 && d[4:2] > 3'h4) || ((a == 8'h0C || a == 8'h47) && d[6:0] < 7'h04));
    sw_w(4'h0, a);
    sw_w(4'h1, d);
    repeat (3) @(posedge sys_clk_i);
    if (ok) m[a] = (a == 8'h40) ? (d & 8'h1F) : d;
    dr(a);
    chk("feedback factor", 12'(term(1)), feedback_factor_o);
    chk("pump code", 12'((m[8'h40] >> 2) & 7), {9'h000, pump_code_o});
    chk("load cap code", 12'(m[8'h13]), {4'h0, load_cap_code_o});
    sw_r(4'h3, s);
    chk("plan status", 12'(st_exp()), {8'h00, s[7], s[3:1]});
  endtask : dw
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // ticks stay quiet while registers change, so the model's term loads stay in step
  always @(posedge sys_clk_i) begin
    tseed      <= lf(tseed);
    ref_tick_i <= run & tseed[0];
    vco_tick_i <= run & (tseed[3] | tseed[6]);
  end
  always @(posedge sys_clk_i) begin
    logic tk;
    if (rst_n_i) begin
      n_tests++;
      if ({bank_tick_o, fb_div_tick_o, ref_div_tick_o} !== exq) begin
        fails++;
        $display("FAIL divider ticks expected %h seen %h", exq,
          {bank_tick_o, fb_div_tick_o, ref_div_tick_o});
      end
    end
    for (int i = 0; i < 10; i++) begin
      tk = (i == 0 || (i > 1 && ((i < 6 ? m[8'h0C] : m[8'h47]) >> 7) != 0)) ? ref_tick_i
                                                                           : vco_tick_i;
      exq[i] = 1'b0;
      if (!rst_n_i) begin
        cnt[i] = 0;
        trm[i] = 0;
      end else if (tk && cnt[i] + 1 >= trm[i]) begin
        exq[i] = 1'b1;
        cnt[i] = 0;
        trm[i] = term(i);
      end else if (tk) begin
        cnt[i]++;
      end
    end
  end
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    fails++;
    $display("FAIL watchdog expected finish seen hang");
    results();
  end
  initial begin
    m[8'h0C] = 8;
    m[8'h47] = 8;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    foreach (adr[j]) dr(adr[j]);
    chk("reset factor", 12'h008, feedback_factor_o);
    $display("test reset values done");
    repeat (24) begin
      seed = lf(seed);
      v = adr[seed % 6];
      seed = lf(seed);
      if (v == 8'h40 && seed[4:2] > 3'h4) seed[4] = 1'b0;
      if ((v == 8'h0C || v == 8'h47) && seed[6:0] < 7'h04) seed[2] = 1'b1;
      dw(v, seed);
    end
    for (int k = 0; k < 5; k++) dw(8'h40, 8'(k << 2) | 8'h03);
    dw(8'h41, 8'hFF);
    dw(8'h42, 8'h80);
    $display("test register writes done");
    dw(8'h40, 8'h14);
    dw(8'h0C, 8'h83);
    sw_r(4'h3, v);
    chk("refused flag", 12'h001, {11'h000, v[0]});
    sw_w(4'h3, 8'h01);
    sw_r(4'h3, v);
    chk("refused flag cleared", 12'h000, {11'h000, v[0]});
    dw(8'h43, 8'h5A);
    sw_r(4'h0, v);
    chk("target readback", 12'h043, {4'h0, v});
    $display("test refused writes done");
    dw(8'h42, 8'h03);
    dw(8'h40, 8'h00);
    dw(8'h41, 8'h04);
    dw(8'h0C, 8'h85);
    dw(8'h47, 8'h04);
    run <= 1'b1;
    repeat (200) @(posedge sys_clk_i);
    run <= 1'b0;
    dw(8'h0C, 8'h07);
    dw(8'h47, 8'h86);
    dw(8'h42, 8'h82);
    run <= 1'b1;
    repeat (300) @(posedge sys_clk_i);
    run <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    $display("test dividers done");
    results();
  end
endmodule : tb
